// [hdl/ser_status_top.sv]
// Status event reporting top: register port, two status groups, error queue
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// ----------------------------------------
// Notes on behaviour
// RULE1: Instrument reset leaves all status state alone
// RULE2: Event read returns contents then clears
// RULE3: Condition read is live and side-effect free
// RULE4: Positive filter enables zero-to-one detection
// RULE5: Negative filter enables one-to-zero detection
// RULE6: Enable mask selects events for summary
// RULE7: Preset fills positive filters with ones
// RULE8: Preset clears negative filters
// RULE9: Preset clears both enable masks
// RULE10: Queue read pops the oldest entry
// RULE11: Entries hold signed error numbers
// RULE12: Empty queue reads as zero
// RULE13: System error read equals queue read
// RULE14: Event latches until read
// RULE15: Summary is OR of masked events
// ----------------------------------------
module ser_status_top (
    input wire logic ref_clk, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [15:0] oper_cond_pin, // Operation condition pins
    input wire logic [15:0] ques_cond_pin, // Questionable condition pins
    input wire ser_pkg::ser_err_type err_in, // Error report from local logic
    output logic oper_summary, // Operation summary bit
    output logic ques_summary, // Questionable summary bit
    output logic queue_nonempty // Error queue holds entries
);
    // ----------------------------------------
    // Condition synchronisers
    // ----------------------------------------
    logic [15:0] cond_meta_reg [ser_pkg::NUM_GRP];
    logic [15:0] cond_sync_reg [ser_pkg::NUM_GRP];
    logic [15:0] cond_pin [ser_pkg::NUM_GRP];

    assign cond_pin[0] = oper_cond_pin;
    assign cond_pin[1] = ques_cond_pin;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic in_groups;
    logic [4:0] sub_ofs;
    logic rd_queue;
    logic do_preset;
    logic instr_reset;
    ser_pkg::ser_grp_req_type grp_req [ser_pkg::NUM_GRP];
    logic [15:0] grp_cond [ser_pkg::NUM_GRP];
    ser_pkg::ser_filter_type grp_filt [ser_pkg::NUM_GRP];
    logic [15:0] grp_event [ser_pkg::NUM_GRP];
    logic grp_summary [ser_pkg::NUM_GRP];

    assign in_groups = reg_addr[7:6] == ser_pkg::AREA_GROUPS;
    assign sub_ofs = reg_addr[4:0];
    assign do_preset = reg_wr && reg_addr == ser_pkg::OFS_PRESET;
    // Both query paths share one pop strobe
    assign rd_queue = reg_rd && (reg_addr == ser_pkg::OFS_QUEUE_NEXT
        || reg_addr == ser_pkg::OFS_SYS_ERROR); // RULE13
    // Accepted and ignored: status state is outside the instrument reset
    assign instr_reset = reg_wr && reg_addr == ser_pkg::OFS_INSTR_RESET; // RULE1

    genvar g;
    generate
        for (g = 0; g < ser_pkg::NUM_GRP; g++) begin : gen_grp
            logic sel;
            assign sel = in_groups && reg_addr[ser_pkg::GRP_SEL_BIT] == 1'(g);

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cond_meta_reg[g] <= 16'h0000;
                    cond_sync_reg[g] <= 16'h0000;
                end else begin
                    cond_meta_reg[g] <= cond_pin[g];
                    cond_sync_reg[g] <= cond_meta_reg[g];
                end
            end

            always_comb begin
                grp_req[g].wr_ptr = reg_wr && sel && sub_ofs == ser_pkg::OFS_PTR;
                grp_req[g].wr_ntr = reg_wr && sel && sub_ofs == ser_pkg::OFS_NTR;
                grp_req[g].wr_enab = reg_wr && sel && sub_ofs == ser_pkg::OFS_ENAB;
                grp_req[g].preset = do_preset;
                grp_req[g].read_event = reg_rd && sel && sub_ofs == ser_pkg::OFS_EVENT; // RULE2
                grp_req[g].wdata = reg_wdata;
            end

            ser_group u_group (
                .ref_clk(ref_clk),
                .rst(rst),
                .cond_s(cond_sync_reg[g]),
                .req(grp_req[g]),
                .cond_reg(grp_cond[g]),
                .filt_reg(grp_filt[g]),
                .event_reg(grp_event[g]),
                .summary_reg(grp_summary[g])
            );
        end
    endgenerate

    assign oper_summary = grp_summary[0];
    assign ques_summary = grp_summary[1];

    // ----------------------------------------
    // Error queue
    // ----------------------------------------
    // A report into a full queue is dropped unless a pop frees a slot in the same cycle, so older entries stay intact
    logic signed [15:0] queue_mem_reg [ser_pkg::QUEUE_DEPTH];
    logic [2:0] head_reg;
    logic [2:0] tail_reg;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic do_pop;
    logic do_push;

    assign do_pop = rd_queue && count_reg != 4'h0; // RULE10 RULE12
    assign do_push = err_in.valid && (count_reg != 4'(ser_pkg::QUEUE_DEPTH) || do_pop);

    always_comb begin
        count_next = count_reg;
        if (do_push && !do_pop) begin
            count_next = 4'(count_reg + 4'h1);
        end else if (do_pop && !do_push) begin
            count_next = 4'(count_reg - 4'h1); // RULE10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            head_reg <= 3'h0;
            tail_reg <= 3'h0;
            count_reg <= 4'h0;
        end else begin
            if (do_pop) begin
                head_reg <= 3'(head_reg + 3'h1); // RULE10
            end
            if (do_push) begin
                tail_reg <= 3'(tail_reg + 3'h1);
            end
            count_reg <= count_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            queue_mem_reg[tail_reg] <= err_in.code; // RULE11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            queue_nonempty <= 1'b0;
        end else begin
            queue_nonempty <= count_next != 4'h0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [15:0] rd_mux;
    logic [15:0] grp_rd [ser_pkg::NUM_GRP];

    always_comb begin
        for (int i = 0; i < ser_pkg::NUM_GRP; i++) begin
            unique case (sub_ofs)
                ser_pkg::OFS_EVENT: grp_rd[i] = grp_event[i]; // RULE2
                ser_pkg::OFS_COND: grp_rd[i] = grp_cond[i]; // RULE3
                ser_pkg::OFS_PTR: grp_rd[i] = grp_filt[i].ptr;
                ser_pkg::OFS_NTR: grp_rd[i] = grp_filt[i].ntr;
                ser_pkg::OFS_ENAB: grp_rd[i] = grp_filt[i].enab;
                default: grp_rd[i] = ser_pkg::READ_ZERO;
            endcase
        end
    end

    always_comb begin
        rd_mux = ser_pkg::READ_ZERO;
        if (in_groups) begin
            rd_mux = grp_rd[reg_addr[ser_pkg::GRP_SEL_BIT]];
        end else if (rd_queue) begin
            rd_mux = (count_reg == 4'h0) ? ser_pkg::NO_ERROR : queue_mem_reg[head_reg]; // RULE12 RULE13
        end else if (reg_addr == ser_pkg::OFS_QUEUE_COUNT) begin
            rd_mux = {12'h000, count_reg};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic cond_rd;
    logic evt_rd;
    logic count_rd;
    logic queue_full;
    logic addr_known;
    assign cond_rd = reg_rd && in_groups && sub_ofs == ser_pkg::OFS_COND;
    assign evt_rd = reg_rd && in_groups && sub_ofs == ser_pkg::OFS_EVENT;
    assign count_rd = reg_rd && reg_addr == ser_pkg::OFS_QUEUE_COUNT;
    assign queue_full = count_reg == 4'(ser_pkg::QUEUE_DEPTH);

    // Offsets that answer a read; the rest must read as zero
    always_comb begin
        addr_known = 1'b0;
        if (in_groups) begin
            addr_known = sub_ofs == ser_pkg::OFS_EVENT || sub_ofs == ser_pkg::OFS_COND
                || sub_ofs == ser_pkg::OFS_PTR || sub_ofs == ser_pkg::OFS_NTR || sub_ofs == ser_pkg::OFS_ENAB;
        end else begin
            addr_known = reg_addr == ser_pkg::OFS_QUEUE_NEXT || reg_addr == ser_pkg::OFS_SYS_ERROR
                || reg_addr == ser_pkg::OFS_QUEUE_COUNT;
        end
    end

    chk_instr_reset_inert: assert property (instr_reset && !err_in.valid |=> // RULE1
        grp_filt[0] == $past(grp_filt[0]) && grp_filt[1] == $past(grp_filt[1]) && count_reg == $past(count_reg))
        else $error("instrument reset disturbed status state");
    chk_cond_read_pure: assert property (cond_rd |=> // RULE3
        reg_rdata == $past(reg_addr[ser_pkg::GRP_SEL_BIT] ? grp_cond[1] : grp_cond[0])
        && grp_filt[0] == $past(grp_filt[0]) && grp_filt[1] == $past(grp_filt[1]))
        else $error("condition read wrong or destructive");
    chk_event_read_data: assert property (evt_rd |=> // RULE2
        reg_rdata == $past(reg_addr[ser_pkg::GRP_SEL_BIT] ? grp_event[1] : grp_event[0]))
        else $error("event read did not return latched events");
    chk_preset_groups: assert property (do_preset |=> grp_filt[0] == grp_filt[1] // RULE7 RULE8 RULE9
        && grp_filt[0].ptr == ser_pkg::PTR_PRESET && grp_filt[0].enab == ser_pkg::ENAB_PRESET
        && grp_filt[0].ntr == ser_pkg::NTR_PRESET)
        else $error("preset did not reach both groups");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == ser_pkg::READ_ZERO)
        else $error("read data not zero outside read cycle");
    chk_unmapped_zero: assert property (reg_rd && !addr_known |=> reg_rdata == ser_pkg::READ_ZERO)
        else $error("unmapped read not zero");

    // ----------------------------------------
    // Queue checks
    // ----------------------------------------
    chk_queue_pop: assert property (rd_queue && count_reg != 4'h0 && !err_in.valid |=> // RULE10
        count_reg == $past(count_reg) - 4'h1 && reg_rdata == $past(queue_mem_reg[head_reg]))
        else $error("queue read did not pop oldest entry");
    chk_queue_push: assert property (err_in.valid && !queue_full && !rd_queue |=> // RULE10
        count_reg == $past(count_reg) + 4'h1)
        else $error("error report not queued");
    chk_full_drop: assert property (err_in.valid && queue_full && !rd_queue |=> // RULE10
        count_reg == $past(count_reg) && tail_reg == $past(tail_reg))
        else $error("report into full queue not dropped");
    chk_count_bound: assert property (count_reg <= 4'(ser_pkg::QUEUE_DEPTH)) // RULE10
        else $error("queue count beyond depth");
    chk_nonempty_flag: assert property (queue_nonempty == (count_reg != 4'h0)) // RULE10
        else $error("nonempty flag disagrees with queue count");
    chk_count_read: assert property (count_rd |=> reg_rdata == {12'h000, $past(count_reg)})
        else $error("queue count read wrong");
    chk_entry_signed: assert property (err_in.valid && count_reg == 4'h0 |=> // RULE11
        queue_mem_reg[head_reg] == $past(err_in.code))
        else $error("error number not stored verbatim");
    chk_empty_zero: assert property (rd_queue && count_reg == 4'h0 && !err_in.valid |=> // RULE12
        reg_rdata == 16'h0000 && count_reg == 4'h0)
        else $error("empty queue read not zero");
    chk_sys_error_path: assert property (reg_rd && count_reg != 4'h0 // RULE13
        && reg_addr == ser_pkg::OFS_SYS_ERROR |=> reg_rdata == $past(queue_mem_reg[head_reg]))
        else $error("system error read differs from queue read");

    cov_preset: cover property (do_preset);
    cov_pop_two: cover property (do_pop ##1 do_pop);
    cov_empty_read: cover property (rd_queue && count_reg == 4'h0);
endmodule

// [inc/ser_pkg.sv]
// Constants and carrier types for the status event reporting block
package ser_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int NUM_GRP = 2;
    localparam int QUEUE_DEPTH = 8;
    localparam int QIDX_W = 3;
    localparam int QCNT_W = 4;
    localparam int GRP_SEL_BIT = 5;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [4:0] OFS_EVENT = 5'h00;
    localparam logic [4:0] OFS_COND = 5'h04;
    localparam logic [4:0] OFS_PTR = 5'h08;
    localparam logic [4:0] OFS_NTR = 5'h0C;
    localparam logic [4:0] OFS_ENAB = 5'h10;
    localparam logic [1:0] AREA_GROUPS = 2'h0;
    localparam logic [7:0] OFS_GRP_OPER = 8'h00;
    localparam logic [7:0] OFS_GRP_QUES = 8'h20;
    localparam logic [7:0] OFS_PRESET = 8'h40;
    localparam logic [7:0] OFS_QUEUE_NEXT = 8'h44;
    localparam logic [7:0] OFS_SYS_ERROR = 8'h48;
    localparam logic [7:0] OFS_INSTR_RESET = 8'h4C;
    localparam logic [7:0] OFS_QUEUE_COUNT = 8'h50;

    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [15:0] PTR_PRESET = 16'hFFFF;
    localparam logic [15:0] NTR_PRESET = 16'h0000;
    localparam logic [15:0] ENAB_PRESET = 16'h0000;
    localparam logic [15:0] FILTER_WMASK = 16'h7FFF;
    localparam logic [15:0] NO_ERROR = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic [15:0] enab;
    } ser_filter_type;

    typedef struct packed {
        logic wr_ptr;
        logic wr_ntr;
        logic wr_enab;
        logic preset;
        logic read_event;
        logic [15:0] wdata;
    } ser_grp_req_type;

    typedef struct packed {
        logic valid;
        logic signed [15:0] code;
    } ser_err_type;
endpackage

// [hdl/ser_group.sv]
// One status group: condition, transition filters, event latch, enable mask, summary
`timescale 1ns/1ps
module ser_group (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [15:0] cond_s, // Synchronised live condition
    input wire ser_pkg::ser_grp_req_type req, // Decoded register request
    output logic [15:0] cond_reg, // Condition register
    output ser_pkg::ser_filter_type filt_reg, // Filters and enable mask
    output logic [15:0] event_reg, // Latched events
    output logic summary_reg // Summary bit for the status byte
);
    logic [15:0] hit;
    logic [15:0] event_next;

    // ----------------------------------------
    // Transition detection
    // ----------------------------------------
    always_comb begin
        hit = (cond_s & ~cond_reg & filt_reg.ptr) | (~cond_s & cond_reg & filt_reg.ntr); // RULE4 RULE5
        // A new event in the clearing cycle survives the read
        event_next = (req.read_event ? 16'h0000 : event_reg) | hit; // RULE2 RULE14
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cond_reg <= 16'h0000;
        end else begin
            cond_reg <= cond_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            event_reg <= 16'h0000;
        end else begin
            event_reg <= event_next; // RULE14
        end
    end

    // ----------------------------------------
    // Filters and mask
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            filt_reg.ptr <= ser_pkg::PTR_PRESET;
            filt_reg.ntr <= ser_pkg::NTR_PRESET;
            filt_reg.enab <= ser_pkg::ENAB_PRESET;
        end else if (req.preset) begin
            filt_reg.ptr <= ser_pkg::PTR_PRESET; // RULE7
            filt_reg.ntr <= ser_pkg::NTR_PRESET; // RULE8
            filt_reg.enab <= ser_pkg::ENAB_PRESET; // RULE9
        end else begin
            if (req.wr_ptr) begin
                filt_reg.ptr <= req.wdata & ser_pkg::FILTER_WMASK; // RULE4
            end
            if (req.wr_ntr) begin
                filt_reg.ntr <= req.wdata & ser_pkg::FILTER_WMASK; // RULE5
            end
            if (req.wr_enab) begin
                filt_reg.enab <= req.wdata & ser_pkg::FILTER_WMASK; // RULE6
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            summary_reg <= 1'b0;
        end else begin
            summary_reg <= |(event_reg & filt_reg.enab); // RULE15
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_event_read_clears: assert property (req.read_event |=> event_reg == $past(hit)) // RULE2
        else $error("event register not cleared by read");
    chk_rise_detected: assert property (!req.read_event |=> // RULE4
        (event_reg & $past(cond_s & ~cond_reg & filt_reg.ptr)) == $past(cond_s & ~cond_reg & filt_reg.ptr))
        else $error("rising transition not latched");
    chk_fall_detected: assert property (!req.read_event |=> // RULE5
        (event_reg & $past(~cond_s & cond_reg & filt_reg.ntr)) == $past(~cond_s & cond_reg & filt_reg.ntr))
        else $error("falling transition not latched");
    chk_event_held: assert property (!req.read_event |=> (event_reg & $past(event_reg)) == $past(event_reg)) // RULE14
        else $error("event bit lost without read");
    chk_enab_write: assert property (req.wr_enab && !req.preset |=> // RULE6
        filt_reg.enab == $past(req.wdata & ser_pkg::FILTER_WMASK))
        else $error("enable mask write lost");
    chk_ptr_write: assert property (req.wr_ptr && !req.preset |=> // RULE4
        filt_reg.ptr == $past(req.wdata & ser_pkg::FILTER_WMASK))
        else $error("positive filter write lost");
    chk_ntr_write: assert property (req.wr_ntr && !req.preset |=> // RULE5
        filt_reg.ntr == $past(req.wdata & ser_pkg::FILTER_WMASK))
        else $error("negative filter write lost");
    chk_preset_ptr: assert property (req.preset |=> filt_reg.ptr == ser_pkg::PTR_PRESET) // RULE7
        else $error("preset did not fill positive filter");
    chk_preset_ntr: assert property (req.preset |=> filt_reg.ntr == ser_pkg::NTR_PRESET) // RULE8
        else $error("preset did not clear negative filter");
    chk_preset_enab: assert property (req.preset |=> filt_reg.enab == ser_pkg::ENAB_PRESET) // RULE9
        else $error("preset did not clear enable mask");
    chk_summary_or: assert property (##1 summary_reg == |($past(event_reg) & $past(filt_reg.enab))) // RULE15
        else $error("summary bit disagrees with masked events");

    cov_rise_event: cover property (|hit ##1 |event_reg);
    cov_summary_set: cover property (summary_reg);
endmodule

// [test/ser_remote_model.sv]
// Remote controller model: register bus master issuing writes and queries
`timescale 1ns/1ps
module ser_remote_model (
    input wire logic ref_clk, // System clock
    output logic [7:0] reg_addr, // Register byte address
    output logic [15:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    input wire logic [15:0] reg_rdata // Read data, cycle after strobe
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines are scrambled so nothing relies on stale values
    task automatic release_bus();
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        release_bus();
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        release_bus();
        // Data stands only in the cycle after the read edge
        #1;
        d = reg_rdata;
    endtask
endmodule

// [test/test_status_event_reporting.sv]
// Self-checking testbench for the status event reporting block
`timescale 1ns/1ps
module test_status_event_reporting;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [15:0] oper_cond_pin = 16'h0000;
    logic [15:0] ques_cond_pin = 16'h0000;
    ser_pkg::ser_err_type err_in = '0;
    logic oper_summary;
    logic ques_summary;
    logic queue_nonempty;
    int failures = 0;
    int num_checks = 0;
    logic [15:0] d;

    always #20 ref_clk = ~ref_clk;

    ser_status_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oper_cond_pin(oper_cond_pin),
        .ques_cond_pin(ques_cond_pin), .err_in(err_in), .oper_summary(oper_summary),
        .ques_summary(ques_summary), .queue_nonempty(queue_nonempty));

    ser_remote_model rc (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] ga(input logic g, input logic [4:0] o);
        return (g ? ser_pkg::OFS_GRP_QUES : ser_pkg::OFS_GRP_OPER) | {3'h0, o};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_filters();
        rc.wr(ga(0, ser_pkg::OFS_PTR), 16'hFFFF);
        rc.wr(ga(1, ser_pkg::OFS_NTR), 16'h8005);
        rc.wr(ga(1, ser_pkg::OFS_ENAB), 16'h1234);
        rc.wr(ser_pkg::OFS_INSTR_RESET, 16'h0001);
        rc.rd(ga(0, ser_pkg::OFS_PTR), d);
        check("oper ptr", d, 16'h7FFF);
        rc.rd(ga(1, ser_pkg::OFS_NTR), d);
        check("ques ntr", d, 16'h0005);
        rc.rd(ga(1, ser_pkg::OFS_ENAB), d);
        check("ques enab", d, 16'h1234);
        rc.wr(ser_pkg::OFS_PRESET, 16'h0000);
        for (int g = 0; g < 2; g++) begin
            rc.rd(ga(g[0], ser_pkg::OFS_PTR), d);
            check("preset ptr", d, 16'hFFFF);
            rc.rd(ga(g[0], ser_pkg::OFS_NTR), d);
            check("preset ntr", d, 16'h0000);
            rc.rd(ga(g[0], ser_pkg::OFS_ENAB), d);
            check("preset enab", d, 16'h0000);
        end
        $display("test filters done");
    endtask

    task automatic t_events(input logic g);
        rc.wr(ga(g, ser_pkg::OFS_PTR), 16'h0001);
        rc.wr(ga(g, ser_pkg::OFS_NTR), 16'h0002);
        rc.wr(ga(g, ser_pkg::OFS_ENAB), 16'h0002);
        rc.rd(ga(g, ser_pkg::OFS_EVENT), d);
        @(posedge ref_clk);
        if (g) ques_cond_pin <= 16'h0003; else oper_cond_pin <= 16'h0003;
        cycles(6);
        rc.rd(ga(g, ser_pkg::OFS_COND), d);
        check("cond live", d, 16'h0003);
        rc.rd(ga(g, ser_pkg::OFS_COND), d);
        check("cond again", d, 16'h0003);
        check("summary masked", {15'h0, g ? ques_summary : oper_summary}, 16'h0000);
        rc.rd(ga(g, ser_pkg::OFS_EVENT), d);
        check("rise event", d, 16'h0001);
        rc.rd(ga(g, ser_pkg::OFS_EVENT), d);
        check("event cleared", d, 16'h0000);
        @(posedge ref_clk);
        if (g) ques_cond_pin <= 16'h0000; else oper_cond_pin <= 16'h0000;
        cycles(6);
        check("summary set", {15'h0, g ? ques_summary : oper_summary}, 16'h0001);
        rc.rd(ga(g, ser_pkg::OFS_EVENT), d);
        check("fall event", d, 16'h0002);
        cycles(2);
        check("summary clear", {15'h0, g ? ques_summary : oper_summary}, 16'h0000);
        $display("test events group %0d done", g);
    endtask

    task automatic t_queue();
        rc.rd(8'hF0, d);
        check("unmapped", d, 16'h0000);
        @(posedge ref_clk);
        err_in <= '{valid: 1'b1, code: -16'sd221};
        @(posedge ref_clk);
        err_in <= '{valid: 1'b1, code: 16'sd5};
        @(posedge ref_clk);
        err_in <= '0;
        #1;
        check("nonempty", {15'h0, queue_nonempty}, 16'h0001);
        rc.rd(ser_pkg::OFS_QUEUE_NEXT, d);
        check("oldest entry", d, 16'hFF23);
        rc.rd(ser_pkg::OFS_SYS_ERROR, d);
        check("second entry", d, 16'h0005);
        cycles(1);
        check("emptied", {15'h0, queue_nonempty}, 16'h0000);
        rc.rd(ser_pkg::OFS_QUEUE_NEXT, d);
        check("empty next", d, 16'h0000);
        rc.rd(ser_pkg::OFS_SYS_ERROR, d);
        check("empty error", d, 16'h0000);
        $display("test queue done");
    endtask

    // Nine reports into an eight-deep queue: the last one is dropped
    task automatic t_queue_full();
        for (int i = 1; i <= 9; i++) begin
            @(posedge ref_clk);
            err_in <= '{valid: 1'b1, code: 16'(i)};
        end
        @(posedge ref_clk);
        err_in <= '0;
        rc.rd(ser_pkg::OFS_QUEUE_COUNT, d);
        check("full count", d, 16'h0008);
        for (int i = 1; i <= 8; i++) begin
            rc.rd(ser_pkg::OFS_QUEUE_NEXT, d);
            check("fifo order", d, 16'(i));
        end
        rc.rd(ser_pkg::OFS_SYS_ERROR, d);
        check("drained", d, 16'h0000);
        $display("test queue full done");
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_filters();
        t_events(1'b0);
        t_events(1'b1);
        t_queue();
        t_queue_full();
        tally_and_finish();
    end

    // Whole sequence needs under 150 cycles
    initial begin
        #(40 * 3000);
        failures++;
        tally_and_finish();
    end
endmodule
